// [verilog/dteu_defs.vh]
`ifndef DTEU_DEFS_VH
`define DTEU_DEFS_VH

// operation codes on instr_op
`define DTEU_OP_NOP 4'h0
`define DTEU_OP_LD_IND 4'h1
`define DTEU_OP_LD_DISP 4'h2
`define DTEU_OP_LD_DIR 4'h3
`define DTEU_OP_ST_IND 4'h4
`define DTEU_OP_ST_DISP 4'h5
`define DTEU_OP_ST_DIR 4'h6
`define DTEU_OP_LPM_R0 4'h7
`define DTEU_OP_LPM_RD 4'h8
`define DTEU_OP_IN 4'h9
`define DTEU_OP_OUT 4'ha
`define DTEU_OP_PUSH 4'hb
`define DTEU_OP_POP 4'hc
`define DTEU_OP_SLEEP 4'hd
`define DTEU_OP_WDR 4'he
`define DTEU_OP_BREAK 4'hf

// pointer select on instr_ptr
`define DTEU_PTR_X 2'h0
`define DTEU_PTR_Y 2'h1
`define DTEU_PTR_Z 2'h2

// pointer mode on instr_mode
`define DTEU_MODE_PLAIN 2'h0
`define DTEU_MODE_POSTINC 2'h1
`define DTEU_MODE_PREDEC 2'h2
`define DTEU_MODE_DISP 2'h3

// low byte index of each pointer pair, and register zero
`define DTEU_REG_X_LO 5'h1a
`define DTEU_REG_Y_LO 5'h1c
`define DTEU_REG_Z_LO 5'h1e
`define DTEU_REG_R0 5'h00

// cycles per instruction class
`define DTEU_CYC_MEM 2'h2
`define DTEU_CYC_LPM 2'h3
`define DTEU_CYC_ONE 2'h1

`define DTEU_SP_RESET 16'h00ff
`define DTEU_PTR_STEP 16'h0001

`endif

// [verilog/dteu_ptr_calc.v]
`timescale 1ns/1ns
`default_nettype none
`include "dteu_defs.vh"

module dteu_ptr_calc (
	input wire [15:0] ptr,
	input wire [1:0] mode,
	input wire [5:0] disp,
	output reg [15:0] acc_addr,
	output reg [15:0] new_ptr
);
	// whole 16-bit pair, so the low byte carries into the high byte
	always @* begin
		acc_addr = ptr;
		new_ptr = ptr;
		case (mode)
		`DTEU_MODE_POSTINC: begin
			new_ptr = ptr + `DTEU_PTR_STEP;
		end
		`DTEU_MODE_PREDEC: begin
			acc_addr = ptr - `DTEU_PTR_STEP;
			new_ptr = ptr - `DTEU_PTR_STEP;
		end
		`DTEU_MODE_DISP: begin
			acc_addr = ptr + {10'h000, disp};
		end
		default: begin
			acc_addr = ptr;
		end
		endcase
	end
endmodule // dteu_ptr_calc

`default_nettype wire

// [verilog/dteu_exec.v]
`timescale 1ns/1ns
`default_nettype none
`include "dteu_defs.vh"

// Functional notes
// - pre-decrement load: decrement pointer, then load; 2 cycles
// - post-increment load: load, then increment pointer; 2 cycles
// - displacement load from Y/Z plus q; pointer kept
// - direct load from address field; 2 cycles
// - pre-decrement store: decrement, then write; 2 cycles
// - post-increment store: write, then increment; 2 cycles
// - displacement store at Y/Z plus q; 2 cycles
// - direct store at address field; 2 cycles
// - program memory byte at Z; 3 cycles
// - I/O in and out take 1 cycle
// - push stores register, moves stack pointer; 2 cycles
// - pop loads top byte, moves stack pointer; 2 cycles
// - sleep takes 1 cycle, signals sleep logic
// - watchdog restart takes 1 cycle, signals watchdog
// - debug halt serves debugger, no fixed length
module dteu_exec #(
	parameter [15:0] SP_RESET = `DTEU_SP_RESET
) (
	input wire core_clk,
	input wire rstn,
	input wire instr_valid,
	output wire instr_ready,
	input wire [3:0] instr_op,
	input wire [4:0] instr_reg,
	input wire [1:0] instr_ptr,
	input wire [1:0] instr_mode,
	input wire [5:0] instr_disp,
	input wire [15:0] instr_addr,
	output wire exec_done,
	input wire ext_we,
	input wire [4:0] ext_addr,
	input wire [7:0] ext_wdata,
	input wire [4:0] peek_addr,
	output reg [7:0] peek_data,
	output reg [15:0] sp,
	output reg [15:0] dmem_addr,
	output reg [7:0] dmem_wdata,
	output reg dmem_re,
	output reg dmem_we,
	input wire [7:0] dmem_rdata,
	output reg [15:0] pmem_addr,
	output reg pmem_re,
	input wire [7:0] pmem_rdata,
	output reg [5:0] io_addr,
	output reg [7:0] io_wdata,
	output reg io_re,
	output reg io_we,
	input wire [7:0] io_rdata,
	output reg sleep_req,
	output reg wdr_pulse,
	output wire debug_halt,
	input wire debug_resume
);
	localparam S_IDLE = 2'h0;
	localparam S_BUSY = 2'h1;
	localparam S_HALT = 2'h2;

	reg [7:0] regs [0:31];
	reg [1:0] state;
	reg [1:0] cnt;
	reg [3:0] op_q;
	reg [4:0] dst_q;
	reg [1:0] next_state;
	reg [1:0] next_cnt;
	reg [15:0] ptr_val;
	reg [1:0] ptr_mode;
	reg [4:0] ptr_idx;
	reg ptr_upd;
	reg [15:0] next_dmem_addr;
	reg next_dmem_re;
	reg next_dmem_we;
	reg [15:0] next_sp;
	reg wb_en;
	reg [7:0] wb_data;
	wire go;
	wire [15:0] acc_addr;
	wire [15:0] new_ptr;
	wire [7:0] src_data;
	integer i;

	// decodes a pointer select to the index of its low byte
	function [4:0] ptr_lo;
		input [1:0] sel;
		begin
			case (sel)
			`DTEU_PTR_X: ptr_lo = `DTEU_REG_X_LO;
			`DTEU_PTR_Y: ptr_lo = `DTEU_REG_Y_LO;
			default: ptr_lo = `DTEU_REG_Z_LO;
			endcase
		end
	endfunction

	// instruction length, so the counter matches the documented cycles
	function [1:0] op_cycles;
		input [3:0] op;
		begin
			case (op)
			`DTEU_OP_LPM_R0, `DTEU_OP_LPM_RD: op_cycles = `DTEU_CYC_LPM;
			`DTEU_OP_LD_IND, `DTEU_OP_LD_DISP, `DTEU_OP_LD_DIR,
			`DTEU_OP_ST_IND, `DTEU_OP_ST_DISP, `DTEU_OP_ST_DIR,
			`DTEU_OP_PUSH, `DTEU_OP_POP: op_cycles = `DTEU_CYC_MEM;
			default: op_cycles = `DTEU_CYC_ONE;
			endcase
		end
	endfunction

	assign instr_ready = (state == S_IDLE);
	assign go = instr_valid && instr_ready;
	assign exec_done = ((state == S_BUSY) && (cnt == 2'h0)) ||
		((state == S_HALT) && debug_resume);
	assign debug_halt = (state == S_HALT);
	assign src_data = regs[instr_reg];

	// pointer choice: program memory reads always use Z
	always @* begin
		ptr_idx = ptr_lo(instr_ptr);
		ptr_mode = instr_mode;
		ptr_upd = 1'b0;
		case (instr_op)
		`DTEU_OP_LD_IND, `DTEU_OP_ST_IND: begin
			if (instr_mode == `DTEU_MODE_DISP) begin
				ptr_mode = `DTEU_MODE_PLAIN;
			end
			ptr_upd = (instr_mode == `DTEU_MODE_POSTINC) ||
				(instr_mode == `DTEU_MODE_PREDEC);
		end
		`DTEU_OP_LD_DISP, `DTEU_OP_ST_DISP: begin
			ptr_mode = `DTEU_MODE_DISP;
		end
		`DTEU_OP_LPM_RD: begin
			ptr_idx = `DTEU_REG_Z_LO;
			ptr_mode = (instr_mode == `DTEU_MODE_POSTINC) ?
				`DTEU_MODE_POSTINC : `DTEU_MODE_PLAIN;
			ptr_upd = (instr_mode == `DTEU_MODE_POSTINC);
		end
		`DTEU_OP_LPM_R0: begin
			ptr_idx = `DTEU_REG_Z_LO;
			ptr_mode = `DTEU_MODE_PLAIN;
		end
		default: begin
			ptr_mode = `DTEU_MODE_PLAIN;
		end
		endcase
		ptr_val = {regs[ptr_idx + 5'h01], regs[ptr_idx]};
	end

	dteu_ptr_calc u_ptr_calc (
		.ptr(ptr_val),
		.mode(ptr_mode),
		.disp(instr_disp),
		.acc_addr(acc_addr),
		.new_ptr(new_ptr)
	);

	// data-space access chosen at acceptance
	always @* begin
		next_dmem_addr = dmem_addr;
		next_dmem_re = 1'b0;
		next_dmem_we = 1'b0;
		next_sp = sp;
		if (go) begin
			case (instr_op)
			`DTEU_OP_LD_IND, `DTEU_OP_LD_DISP: begin
				next_dmem_addr = acc_addr;
				next_dmem_re = 1'b1;
			end
			`DTEU_OP_LD_DIR: begin
				next_dmem_addr = instr_addr;
				next_dmem_re = 1'b1;
			end
			`DTEU_OP_ST_IND, `DTEU_OP_ST_DISP: begin
				next_dmem_addr = acc_addr;
				next_dmem_we = 1'b1;
			end
			`DTEU_OP_ST_DIR: begin
				next_dmem_addr = instr_addr;
				next_dmem_we = 1'b1;
			end
			`DTEU_OP_PUSH: begin
				next_dmem_addr = sp;
				next_dmem_we = 1'b1;
				next_sp = sp - `DTEU_PTR_STEP;
			end
			`DTEU_OP_POP: begin
				next_dmem_addr = sp + `DTEU_PTR_STEP;
				next_dmem_re = 1'b1;
				next_sp = sp + `DTEU_PTR_STEP;
			end
			default: begin
				next_dmem_re = 1'b0;
			end
			endcase
		end
	end

	// sequencing: one busy cycle per documented clock
	always @* begin
		next_state = state;
		next_cnt = cnt;
		case (state)
		S_IDLE: begin
			if (go) begin
				if (instr_op == `DTEU_OP_BREAK) begin
					next_state = S_HALT;
				end else begin
					next_state = S_BUSY;
					next_cnt = op_cycles(instr_op) - 2'h1;
				end
			end
		end
		S_BUSY: begin
			if (cnt == 2'h0) begin
				next_state = S_IDLE;
			end else begin
				next_cnt = cnt - 2'h1;
			end
		end
		S_HALT: begin
			if (debug_resume) begin
				next_state = S_IDLE;
			end
		end
		default: begin
			next_state = S_IDLE;
		end
		endcase
	end

	// write-back in the last busy cycle; no status flag is ever touched
	always @* begin
		wb_en = 1'b0;
		wb_data = dmem_rdata;
		if ((state == S_BUSY) && (cnt == 2'h0)) begin
			case (op_q)
			`DTEU_OP_LD_IND, `DTEU_OP_LD_DISP, `DTEU_OP_LD_DIR, `DTEU_OP_POP: begin
				wb_en = 1'b1;
			end
			`DTEU_OP_LPM_R0, `DTEU_OP_LPM_RD: begin
				wb_en = 1'b1;
				wb_data = pmem_rdata;
			end
			`DTEU_OP_IN: begin
				wb_en = 1'b1;
				wb_data = io_rdata;
			end
			default: begin
				wb_en = 1'b0;
			end
			endcase
		end
	end

	always @(posedge core_clk) begin
		if (!rstn) begin
			state <= S_IDLE;
			cnt <= 2'h0;
			op_q <= `DTEU_OP_NOP;
			dst_q <= `DTEU_REG_R0;
			sp <= SP_RESET;
			dmem_addr <= 16'h0000;
			dmem_re <= 1'b0;
			dmem_we <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			sp <= next_sp;
			dmem_addr <= next_dmem_addr;
			dmem_re <= next_dmem_re;
			dmem_we <= next_dmem_we;
			if (go) begin
				op_q <= instr_op;
				dst_q <= (instr_op == `DTEU_OP_LPM_R0) ? `DTEU_REG_R0 : instr_reg;
			end
		end
	end

	// strobes to program memory, I/O space, sleep and watchdog
	always @(posedge core_clk) begin
		if (!rstn) begin
			dmem_wdata <= 8'h00;
			pmem_addr <= 16'h0000;
			pmem_re <= 1'b0;
			io_addr <= 6'h00;
			io_wdata <= 8'h00;
			io_re <= 1'b0;
			io_we <= 1'b0;
			sleep_req <= 1'b0;
			wdr_pulse <= 1'b0;
		end else begin
			pmem_re <= go && ((instr_op == `DTEU_OP_LPM_R0) || (instr_op == `DTEU_OP_LPM_RD));
			io_re <= go && (instr_op == `DTEU_OP_IN);
			io_we <= go && (instr_op == `DTEU_OP_OUT);
			sleep_req <= go && (instr_op == `DTEU_OP_SLEEP);
			wdr_pulse <= go && (instr_op == `DTEU_OP_WDR);
			if (go) begin
				dmem_wdata <= src_data;
				io_addr <= instr_addr[5:0];
				io_wdata <= src_data;
				if ((instr_op == `DTEU_OP_LPM_R0) || (instr_op == `DTEU_OP_LPM_RD)) begin
					pmem_addr <= acc_addr;
				end
			end
		end
	end

	// register file; a load into a pointer byte beats that pointer's step
	always @(posedge core_clk) begin
		if (!rstn) begin
			for (i = 0; i < 32; i = i + 1) begin
				regs[i] <= 8'h00;
			end
			peek_data <= 8'h00;
		end else begin
			peek_data <= regs[peek_addr];
			if (go && ptr_upd) begin
				regs[ptr_idx] <= new_ptr[7:0];
				regs[ptr_idx + 5'h01] <= new_ptr[15:8];
			end
			if (ext_we && instr_ready && !go) begin
				regs[ext_addr] <= ext_wdata;
			end
			if (wb_en) begin
				regs[dst_q] <= wb_data;
			end
		end
	end
endmodule // dteu_exec

`default_nettype wire

// [testbench/dteu_mem_model.sv]
`timescale 1ns/1ns
`default_nettype none
module dteu_mem_model (
	input wire logic core_clk,
	input wire logic [15:0] dmem_addr,
	input wire logic [7:0] dmem_wdata,
	input wire logic dmem_re,
	input wire logic dmem_we,
	output var logic [7:0] dmem_rdata,
	input wire logic [15:0] pmem_addr,
	input wire logic pmem_re,
	output var logic [7:0] pmem_rdata,
	input wire logic [5:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic io_re,
	input wire logic io_we,
	output logic [7:0] io_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] io_last = 8'h00;
	logic pwait = 1'b0;
	initial begin
		dmem_rdata = 8'h00;
		pmem_rdata = 8'h00;
		for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'h3c;
	end
	// lines toggle outside the read slot, so a stale byte never looks valid
	always @(posedge core_clk) begin
		dmem_rdata <= dmem_re ? mem[dmem_addr] : ~dmem_rdata;
		pwait <= pmem_re;
		pmem_rdata <= pwait ? pmem_addr[7:0] + 8'h41 : ~pmem_rdata;
		if (dmem_we) mem[dmem_addr] <= dmem_wdata;
		if (io_we) io_last <= io_wdata ^ {2'h0, io_addr};
	end
	assign io_rdata = io_re ? {2'h0, io_addr} ^ 8'ha5 : {8{core_clk}} ^ 8'h33;
endmodule // dteu_mem_model
`default_nettype wire

// [testbench/dteu_exec_checker.sv]
`timescale 1ns/1ns
`default_nettype none
`include "dteu_defs.vh"
module dteu_exec_checker (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic instr_valid,
	input wire logic instr_ready,
	input wire logic [3:0] instr_op,
	input wire logic exec_done,
	input wire logic [15:0] sp,
	input wire logic [15:0] dmem_addr,
	input wire logic dmem_re,
	input wire logic dmem_we,
	input wire logic pmem_re,
	input wire logic io_re,
	input wire logic io_we,
	input wire logic sleep_req,
	input wire logic wdr_pulse,
	input wire logic debug_halt,
	input wire logic debug_resume
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	wire go = instr_valid && instr_ready;
	a_ld_len: assert property (go && instr_op == `DTEU_OP_LD_IND |=>
		dmem_re && !exec_done ##1 exec_done) else $error("load length");
	a_lpm_len: assert property (go && (instr_op == `DTEU_OP_LPM_R0 ||
		instr_op == `DTEU_OP_LPM_RD) |=> pmem_re ##1 !exec_done ##1 exec_done)
		else $error("lpm length");
	a_io_one: assert property (go && (instr_op == `DTEU_OP_IN ||
		instr_op == `DTEU_OP_OUT) |=> exec_done && (io_re || io_we)) else $error("io");
	a_push_sp: assert property (go && instr_op == `DTEU_OP_PUSH |=>
		dmem_we && dmem_addr == $past(sp) && sp == $past(sp) - 16'h0001) else $error("push");
	a_pop_sp: assert property (go && instr_op == `DTEU_OP_POP |=>
		dmem_re && sp == $past(sp) + 16'h0001 && dmem_addr == sp) else $error("pop");
	a_sleep_one: assert property (go && instr_op == `DTEU_OP_SLEEP |=>
		sleep_req && exec_done) else $error("sleep");
	a_wdr_one: assert property (go && instr_op == `DTEU_OP_WDR |=>
		wdr_pulse && exec_done) else $error("wdr");
	a_halt_hold: assert property (debug_halt && !debug_resume |=> debug_halt)
		else $error("halt dropped");
endmodule // dteu_exec_checker
bind dteu_exec dteu_exec_checker i_chk (.core_clk, .rstn, .instr_valid, .instr_ready,
	.instr_op, .exec_done, .sp, .dmem_addr, .dmem_re, .dmem_we, .pmem_re, .io_re, .io_we,
	.sleep_req, .wdr_pulse, .debug_halt, .debug_resume);
`default_nettype wire

// [testbench/dteu_exec_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "dteu_defs.vh"
module dteu_exec_tb_top;
	logic core_clk = 1'b0, rstn = 1'b0, instr_valid = 1'b0, ext_we = 1'b0, debug_resume = 1'b0;
	logic [3:0] instr_op = '0;
	logic [4:0] instr_reg = '0, ext_addr = '0, peek_addr = '0;
	logic [1:0] instr_ptr = '0, instr_mode = '0;
	logic [5:0] instr_disp = '0, io_addr;
	logic [15:0] instr_addr = '0, sp, dmem_addr, pmem_addr;
	logic [7:0] ext_wdata = '0, peek_data, dmem_wdata, dmem_rdata, pmem_rdata, io_wdata, io_rdata;
	logic instr_ready, exec_done, dmem_re, dmem_we, pmem_re, io_re, io_we;
	logic sleep_req, wdr_pulse, debug_halt;
	int fail_count = 0, samples_checked = 0;
	always #25 core_clk = ~core_clk;
	dteu_exec i_dut (.core_clk, .rstn, .instr_valid, .instr_ready, .instr_op, .instr_reg,
		.instr_ptr, .instr_mode, .instr_disp, .instr_addr, .exec_done, .ext_we, .ext_addr,
		.ext_wdata, .peek_addr, .peek_data, .sp, .dmem_addr, .dmem_wdata, .dmem_re, .dmem_we,
		.dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata, .io_addr, .io_wdata, .io_re, .io_we,
		.io_rdata, .sleep_req, .wdr_pulse, .debug_halt, .debug_resume);
	dteu_mem_model i_mem (.core_clk, .dmem_addr, .dmem_wdata, .dmem_re, .dmem_we, .dmem_rdata,
		.pmem_addr, .pmem_re, .pmem_rdata, .io_addr, .io_wdata, .io_re, .io_we, .io_rdata);
	task automatic finish_test();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic setr(input logic [4:0] r, input logic [7:0] v);
		@(posedge core_clk);
		ext_we <= 1'b1;
		ext_addr <= r;
		ext_wdata <= v;
		@(posedge core_clk);
		ext_we <= 1'b0;
	endtask
	task automatic getr(input logic [4:0] r, input logic [15:0] v);
		@(posedge core_clk);
		peek_addr <= r;
		repeat (2) @(posedge core_clk);
		#1 chk({8'h00, peek_data}, v);
	endtask
	task automatic setp(input logic [4:0] lo, input logic [15:0] v);
		setr(lo, v[7:0]);
		setr(lo + 5'h01, v[15:8]);
	endtask
	task automatic getp(input logic [4:0] lo, input logic [15:0] v);
		getr(lo, {8'h00, v[7:0]});
		getr(lo + 5'h01, {8'h00, v[15:8]});
	endtask
	// length is counted from the taking edge up to the done cycle
	task automatic run(input logic [3:0] op, input logic [4:0] r, input logic [1:0] p,
		input logic [1:0] m, input logic [15:0] a, input int cyc);
		int n;
		@(posedge core_clk);
		instr_valid <= 1'b1;
		instr_op <= op;
		instr_reg <= r;
		instr_ptr <= p;
		instr_mode <= m;
		instr_addr <= a;
		instr_disp <= a[5:0];
		@(posedge core_clk);
		instr_valid <= 1'b0;
		n = 1;
		#1;
		while (exec_done !== 1'b1 && n < 8) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk(n[15:0], cyc[15:0]);
		@(posedge core_clk);
	endtask
	task automatic t_ind();
		setp(`DTEU_REG_X_LO, 16'h0000);
		run(`DTEU_OP_LD_IND, 5'h05, `DTEU_PTR_X, `DTEU_MODE_PREDEC, 16'h0000, 2);
		getr(5'h05, 16'h003c);
		getp(`DTEU_REG_X_LO, 16'hffff);
		run(`DTEU_OP_LD_IND, 5'h06, `DTEU_PTR_X, `DTEU_MODE_POSTINC, 16'h0000, 2);
		getr(5'h06, 16'h003c);
		getp(`DTEU_REG_X_LO, 16'h0000);
	endtask
	task automatic t_store();
		setr(5'h07, 8'h9a);
		setp(`DTEU_REG_Y_LO, 16'h00ff);
		run(`DTEU_OP_ST_IND, 5'h07, `DTEU_PTR_Y, `DTEU_MODE_POSTINC, 16'h0000, 2);
		getp(`DTEU_REG_Y_LO, 16'h0100);
		run(`DTEU_OP_LD_IND, 5'h08, `DTEU_PTR_Y, `DTEU_MODE_PREDEC, 16'h0000, 2);
		getr(5'h08, 16'h009a);
		setp(`DTEU_REG_Z_LO, 16'h0010);
		run(`DTEU_OP_ST_IND, 5'h07, `DTEU_PTR_Z, `DTEU_MODE_PREDEC, 16'h0000, 2);
		run(`DTEU_OP_LD_DIR, 5'h09, 2'h0, 2'h0, 16'h000f, 2);
		getr(5'h09, 16'h009a);
		// plain form: no step, so the pointer check below also covers it
		run(`DTEU_OP_LD_IND, 5'h10, `DTEU_PTR_Z, `DTEU_MODE_PLAIN, 16'h0000, 2);
		getr(5'h10, 16'h009a);
		getp(`DTEU_REG_Z_LO, 16'h000f);
	endtask
	task automatic t_offset();
		setr(5'h0a, 8'h5c);
		run(`DTEU_OP_ST_DISP, 5'h0a, `DTEU_PTR_Z, 2'h0, 16'h0003, 2);
		run(`DTEU_OP_LD_DISP, 5'h0b, `DTEU_PTR_Z, 2'h0, 16'h0003, 2);
		getr(5'h0b, 16'h005c);
		getp(`DTEU_REG_Z_LO, 16'h000f);
		run(`DTEU_OP_ST_DIR, 5'h0a, 2'h0, 2'h0, 16'h0120, 2);
		run(`DTEU_OP_LD_DIR, 5'h0c, 2'h0, 2'h0, 16'h0120, 2);
		getr(5'h0c, 16'h005c);
	endtask
	task automatic t_lpm_io();
		run(`DTEU_OP_LPM_RD, 5'h0d, `DTEU_PTR_Z, `DTEU_MODE_POSTINC, 16'h0000, 3);
		getr(5'h0d, 16'h0050);
		getp(`DTEU_REG_Z_LO, 16'h0010);
		run(`DTEU_OP_LPM_R0, 5'h00, `DTEU_PTR_Z, 2'h0, 16'h0000, 3);
		getr(`DTEU_REG_R0, 16'h0051);
		run(`DTEU_OP_LPM_RD, 5'h11, `DTEU_PTR_Z, `DTEU_MODE_PLAIN, 16'h0000, 3);
		getr(5'h11, 16'h0051);
		getp(`DTEU_REG_Z_LO, 16'h0010);
		run(`DTEU_OP_IN, 5'h0e, 2'h0, 2'h0, 16'h0005, 1);
		getr(5'h0e, 16'h00a0);
		run(`DTEU_OP_OUT, 5'h0a, 2'h0, 2'h0, 16'h0007, 1);
		// the model takes the byte on the edge run returns at, so look just after it
		#1 chk({8'h00, i_mem.io_last}, 16'h005b);
	endtask
	task automatic t_stack();
		chk(sp, 16'h00ff);
		run(`DTEU_OP_PUSH, 5'h0a, 2'h0, 2'h0, 16'h0000, 2);
		chk(sp, 16'h00fe);
		run(`DTEU_OP_POP, 5'h0f, 2'h0, 2'h0, 16'h0000, 2);
		getr(5'h0f, 16'h005c);
		chk(sp, 16'h00ff);
	endtask
	task automatic t_ctl();
		run(`DTEU_OP_SLEEP, 5'h00, 2'h0, 2'h0, 16'h0000, 1);
		run(`DTEU_OP_WDR, 5'h00, 2'h0, 2'h0, 16'h0000, 1);
		run(`DTEU_OP_NOP, 5'h00, 2'h0, 2'h0, 16'h0000, 1);
		// halt length is set only by the resume request
		fork
			run(`DTEU_OP_BREAK, 5'h00, 2'h0, 2'h0, 16'h0000, 3);
			begin
				repeat (4) @(posedge core_clk);
				debug_resume <= 1'b1;
				@(posedge core_clk);
				debug_resume <= 1'b0;
			end
		join
	endtask
	initial begin
		repeat (3000) @(posedge core_clk);
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		t_ind();
		t_store();
		t_offset();
		t_lpm_io();
		t_stack();
		t_ctl();
		finish_test();
	end
endmodule // dteu_exec_tb_top
`default_nettype wire
